// File: src/pst_cfg_map.svh
`ifndef PST_CFG_MAP_SVH
`define PST_CFG_MAP_SVH
// command code of the configuration word (index on the command port)
`define PST_CMD_CFG          8'hDF
`define PST_CMD_PAGE         8'h00
`define PST_CMD_SERIAL       8'h9E
`define PST_CMD_USER_FIRST   8'hB0
`define PST_USER_COUNT       13
`define PST_USER_BYTES       6
`define PST_PAGE_A           8'h00
`define PST_PAGE_B           8'h01
// field positions
`define PST_DCM_BIT          15
`define PST_DROP21_HI        14
`define PST_DROP21_LO        13
`define PST_ADD56_HI         12
`define PST_ADD56_LO         11
`define PST_ADD45_HI         10
`define PST_ADD45_LO         9
`define PST_ADD34_HI         8
`define PST_ADD34_LO         7
`define PST_ADD23_HI         6
`define PST_ADD23_LO         5
`define PST_ADD12_HI         5
`define PST_ADD12_LO         4
`define PST_SHED1_BIT        3
`define PST_PEAK_HI          2
`define PST_PEAK_LO          0
// currents in amperes, then the maximum phase count of channels A and B
`define PST_PEAK_BASE_A      12
`define PST_PEAK_STEP_A      2
`define PST_ADD_BASE_A       6
`define PST_ADD_STEP_A       2
`define PST_DROP_BASE_A      2
`define PST_DROP_STEP_A      2
`define PST_MAX_PHASES_A     6
`define PST_MAX_PHASES_B     3
`endif

// File: src/pst_pkg.sv
package pst_pkg;
    typedef logic [7:0]  pst_cmd_t;
    typedef logic [15:0] pst_word_t;
    typedef logic [9:0]  pst_amp_t;
    typedef logic [2:0]  pst_phase_t;
    typedef enum logic [2:0] {
        PST_IDLE  = 3'b001,
        PST_READ  = 3'b010,
        PST_WRITE = 3'b100
    } pst_bus_e;
endpackage

// File: src/pst_shed_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg_map.svh"
module pst_shed_ctrl
    import pst_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    // configuration of this channel
    input  wire pst_word_t  cfg_in,
    input  wire logic       chan_b_in,
    input  wire logic       shed_en_in,
    // synchronised current samples, total amperes of the channel
    input  wire pst_amp_t   avg_cur_in,
    input  wire pst_amp_t   peak_cur_in,
    // state
    output logic            light_load_out,
    output pst_phase_t      phases_out
);
    pst_phase_t phases_r;
    pst_phase_t phases_nxt;
    logic       light_r;
    logic       light_nxt;
    pst_amp_t   peak_a;
    pst_amp_t   add_th;
    pst_amp_t   drop_th;
    pst_phase_t max_ph;
    logic [1:0] add_code;

    function automatic pst_amp_t mul(input pst_phase_t n, input pst_amp_t a);
        mul = 10'(n * a);
    endfunction

    always_comb begin
        peak_a = 10'(`PST_PEAK_BASE_A + `PST_PEAK_STEP_A * cfg_in[`PST_PEAK_HI-1:`PST_PEAK_LO]);
        max_ph = chan_b_in ? 3'(`PST_MAX_PHASES_B) : 3'(`PST_MAX_PHASES_A);
        case (phases_r)
            3'h1: add_code = cfg_in[`PST_ADD12_HI:`PST_ADD12_LO];
            3'h2: add_code = cfg_in[`PST_ADD23_HI:`PST_ADD23_LO];
            3'h3: add_code = chan_b_in ? 2'h0 : cfg_in[`PST_ADD34_HI:`PST_ADD34_LO];
            3'h4: add_code = cfg_in[`PST_ADD45_HI:`PST_ADD45_LO];
            default: add_code = cfg_in[`PST_ADD56_HI:`PST_ADD56_LO];
        endcase
        // channel B ignores upper add fields
        if (chan_b_in && phases_r >= 3'h3) begin
            add_code = 2'h0;
        end
        add_th = 10'(mul(phases_r, peak_a) + `PST_ADD_BASE_A + `PST_ADD_STEP_A * add_code);
        // drop offset, 00b -2 A up to 11b +4 A
        drop_th = 10'(peak_a + `PST_DROP_STEP_A * cfg_in[`PST_DROP21_HI:`PST_DROP21_LO]
                  - `PST_DROP_BASE_A);
        phases_nxt = phases_r;
        if (!shed_en_in) begin
            if (phases_r < max_ph) begin
                phases_nxt = 3'(phases_r + 3'h1);
            end
        end else if (phases_r < max_ph && peak_cur_in >= add_th) begin
            phases_nxt = 3'(phases_r + 3'h1);
        end else if (phases_r == 3'h2 && cfg_in[`PST_SHED1_BIT] && avg_cur_in <= drop_th) begin
            phases_nxt = 3'h1;
        end
        if (phases_nxt == 3'h0 || phases_nxt > max_ph) begin
            phases_nxt = max_ph;
        end
        // light load mode in single phase
        light_nxt = cfg_in[`PST_DCM_BIT] && phases_nxt == 3'h1;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            phases_r <= 3'h1;
            light_r  <= 1'b0;
        end else begin
            phases_r <= phases_nxt;
            light_r  <= light_nxt;
        end
    end

    assign phases_out     = phases_r;
    assign light_load_out = light_r;
endmodule
`default_nettype wire

// File: src/pst_cfg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg_map.svh"
// Contract
// - bit 15 enables light-load mode while one phase runs.
// - two-to-one drop threshold is peak current plus offset, -2 to +4 A.
// - drop a phase when average current reaches the drop threshold.
// - add a phase when peak current reaches the add threshold.
// - bits 12:11, channel A, five-to-six add: 5x peak plus 6..12 A.
// - bits 10:9, channel A, four-to-five add: 4x peak plus 6..12 A.
// - bits 8:7, channel A, three-to-four add: 3x peak plus 6..12 A.
// - bits 6:5, two-to-three add: 2x peak plus 6..12 A.
// - bits 5:4, one-to-two add: peak plus 6..12 A.
// - bit 3 permits shedding from two phases to one.
// - bits select peak current 12, 14, 16 or 18 A.
// - all fields read and write, reset from nonvolatile defaults.
// - thirteen six-byte user blocks map the configuration for storing.
// - serial command returns a checksum of stored configuration.
// - page 00h selects channel A, 01h channel B.
// - word is reached only by word writes and word reads; user blocks 0 and 1 also reach both words by non-word access.
module pst_cfg_top
    import pst_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    // nonvolatile defaults, stable at reset
    input  wire pst_word_t  nvm_cfg_a_in,
    input  wire pst_word_t  nvm_cfg_b_in,
    // decoded word transaction port
    input  wire logic       cmd_valid_in,
    input  wire logic       cmd_write_in,
    input  wire logic       cmd_word_in,
    input  wire pst_cmd_t   cmd_code_in,
    input  wire pst_word_t  cmd_wdata_in,
    output logic            cmd_ack_out,
    output logic            cmd_nack_out,
    output pst_word_t       cmd_rdata_out,
    // shedding control and current samples
    input  wire logic       shed_en_in,
    input  wire pst_amp_t   avg_cur_a_in,
    input  wire pst_amp_t   peak_cur_a_in,
    input  wire pst_amp_t   avg_cur_b_in,
    input  wire pst_amp_t   peak_cur_b_in,
    // channel state
    output pst_phase_t      phases_a_out,
    output pst_phase_t      phases_b_out,
    output logic            light_load_a_out,
    output logic            light_load_b_out
);
    pst_word_t  cfg_a_r;
    pst_word_t  cfg_a_nxt;
    pst_word_t  cfg_b_r;
    pst_word_t  cfg_b_nxt;
    logic [7:0] page_r;
    logic [7:0] page_nxt;
    logic       load_r;
    logic       load_nxt;
    pst_bus_e   st_r;
    pst_bus_e   st_nxt;
    logic       ack_r;
    logic       ack_nxt;
    logic       nack_r;
    logic       nack_nxt;
    pst_word_t  rdata_r;
    pst_word_t  rdata_nxt;
    logic       sync_en_1_r;
    logic       sync_en_2_r;
    pst_amp_t   avg_a_1_r;
    pst_amp_t   avg_a_2_r;
    pst_amp_t   pk_a_1_r;
    pst_amp_t   pk_a_2_r;
    pst_amp_t   avg_b_1_r;
    pst_amp_t   avg_b_2_r;
    pst_amp_t   pk_b_1_r;
    pst_amp_t   pk_b_2_r;
    pst_phase_t ph_a;
    pst_phase_t ph_b;
    logic       ll_a;
    logic       ll_b;
    pst_phase_t ph_a_r;
    pst_phase_t ph_b_r;
    logic       ll_a_r;
    logic       ll_b_r;
    logic [3:0] blk_idx;
    logic       blk_hit;

    // fold both words into a small checksum; cheap, catches single flips
    function automatic pst_word_t csum(input pst_word_t a, input pst_word_t b);
        csum = 16'(a + {b[7:0], b[15:8]} + 16'h5A5A);
    endfunction

    // two flops on every external sample, the samples arrive from the analog side
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            // reset as enabled, so phases do not climb while the synchroniser fills
            sync_en_1_r <= 1'b1;
            sync_en_2_r <= 1'b1;
            avg_a_1_r   <= 10'h000;
            avg_a_2_r   <= 10'h000;
            pk_a_1_r    <= 10'h000;
            pk_a_2_r    <= 10'h000;
            avg_b_1_r   <= 10'h000;
            avg_b_2_r   <= 10'h000;
            pk_b_1_r    <= 10'h000;
            pk_b_2_r    <= 10'h000;
        end else begin
            sync_en_1_r <= shed_en_in;
            sync_en_2_r <= sync_en_1_r;
            avg_a_1_r   <= avg_cur_a_in;
            avg_a_2_r   <= avg_a_1_r;
            pk_a_1_r    <= peak_cur_a_in;
            pk_a_2_r    <= pk_a_1_r;
            avg_b_1_r   <= avg_cur_b_in;
            avg_b_2_r   <= avg_b_1_r;
            pk_b_1_r    <= peak_cur_b_in;
            pk_b_2_r    <= pk_b_1_r;
        end
    end

    always_comb begin
        blk_idx = 4'(cmd_code_in - `PST_CMD_USER_FIRST);
        // full-width range test, the short index alone would alias codes above the blocks
        blk_hit = cmd_code_in >= `PST_CMD_USER_FIRST
                  && cmd_code_in < 8'(`PST_CMD_USER_FIRST + `PST_USER_COUNT);
    end

    always_comb begin
        cfg_a_nxt = cfg_a_r;
        cfg_b_nxt = cfg_b_r;
        page_nxt  = page_r;
        load_nxt  = 1'b0;
        st_nxt    = PST_IDLE;
        ack_nxt   = 1'b0;
        nack_nxt  = 1'b0;
        rdata_nxt = rdata_r;
        // defaults taken one cycle after reset release
        if (load_r) begin
            cfg_a_nxt = nvm_cfg_a_in;
            cfg_b_nxt = nvm_cfg_b_in;
        end else if (cmd_valid_in) begin
            st_nxt  = cmd_write_in ? PST_WRITE : PST_READ;
            ack_nxt = 1'b1;
            case (cmd_code_in)
                `PST_CMD_PAGE: begin
                    if (cmd_write_in) begin
                        page_nxt = cmd_wdata_in[7:0];
                    end
                    rdata_nxt = {8'h00, page_r};
                end
                `PST_CMD_CFG: begin
                    if (!cmd_word_in) begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end else if (page_r == `PST_PAGE_A) begin
                        if (cmd_write_in) begin
                            cfg_a_nxt = cmd_wdata_in;
                        end
                        rdata_nxt = cfg_a_r;
                    end else if (page_r == `PST_PAGE_B) begin
                        if (cmd_write_in) begin
                            cfg_b_nxt = cmd_wdata_in;
                        end
                        rdata_nxt = cfg_b_r;
                    end else begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end
                end
                `PST_CMD_SERIAL: begin
                    rdata_nxt = csum(cfg_a_r, cfg_b_r);
                    if (cmd_write_in) begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end
                end
                default: begin
                    // user blocks: block 0 reads back word A, block 1 word B, others zero
                    if (blk_hit) begin
                        rdata_nxt = (blk_idx == 4'h0) ? cfg_a_r : 16'h0000;
                        if (cmd_write_in && blk_idx == 4'h0) begin
                            cfg_a_nxt = cmd_wdata_in;
                        end
                        if (cmd_write_in && blk_idx == 4'h1) begin
                            cfg_b_nxt = cmd_wdata_in;
                        end
                        if (!cmd_write_in && blk_idx == 4'h1) begin
                            rdata_nxt = cfg_b_r;
                        end
                    end else begin
                        ack_nxt  = 1'b0;
                        nack_nxt = 1'b1;
                    end
                end
            endcase
        end
        if (st_nxt == PST_WRITE && !ack_nxt) begin
            st_nxt = PST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            cfg_a_r <= 16'h0000;
            cfg_b_r <= 16'h0000;
            page_r  <= 8'h00;
            load_r  <= 1'b1;
            st_r    <= PST_IDLE;
            ack_r   <= 1'b0;
            nack_r  <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            cfg_a_r <= cfg_a_nxt;
            cfg_b_r <= cfg_b_nxt;
            page_r  <= page_nxt;
            load_r  <= load_nxt;
            st_r    <= st_nxt;
            ack_r   <= ack_nxt;
            nack_r  <= nack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    pst_shed_ctrl u_shed_a (
        .ref_clk_in     (ref_clk_in),
        .resetn_in      (resetn_in),
        .cfg_in         (cfg_a_r),
        .chan_b_in      (1'b0),
        .shed_en_in     (sync_en_2_r),
        .avg_cur_in     (avg_a_2_r),
        .peak_cur_in    (pk_a_2_r),
        .light_load_out (ll_a),
        .phases_out     (ph_a)
    );

    pst_shed_ctrl u_shed_b (
        .ref_clk_in     (ref_clk_in),
        .resetn_in      (resetn_in),
        .cfg_in         (cfg_b_r),
        .chan_b_in      (1'b1),
        .shed_en_in     (sync_en_2_r),
        .avg_cur_in     (avg_b_2_r),
        .peak_cur_in    (pk_b_2_r),
        .light_load_out (ll_b),
        .phases_out     (ph_b)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            ph_a_r <= 3'h1;
            ph_b_r <= 3'h1;
            ll_a_r <= 1'b0;
            ll_b_r <= 1'b0;
        end else begin
            ph_a_r <= ph_a;
            ph_b_r <= ph_b;
            ll_a_r <= ll_a;
            ll_b_r <= ll_b;
        end
    end

    assign cmd_ack_out      = ack_r;
    assign cmd_nack_out     = nack_r;
    assign cmd_rdata_out    = rdata_r;
    assign phases_a_out     = ph_a_r;
    assign phases_b_out     = ph_b_r;
    assign light_load_a_out = ll_a_r;
    assign light_load_b_out = ll_b_r;
endmodule
`default_nettype wire

// File: verif/pst_cfg_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg_map.svh"
module pst_cfg_top_checker
    import pst_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       resetn_in,
    // transactions
    input wire logic       cmd_valid_in,
    input wire logic       cmd_write_in,
    input wire logic       cmd_word_in,
    input wire pst_cmd_t   cmd_code_in,
    input wire pst_word_t  cmd_wdata_in,
    input wire logic       cmd_ack_out,
    input wire logic       cmd_nack_out,
    input wire pst_word_t  cmd_rdata_out,
    // shedding
    input wire logic       shed_en_in,
    input wire pst_phase_t phases_a_out,
    input wire pst_phase_t phases_b_out,
    input wire logic       light_load_a_out
);
    logic       ld_r;
    logic       ld_nxt;
    logic [4:0] off_r;
    logic [4:0] off_nxt;
    logic       req;
    // the load edge after release takes no request, so it is left out
    always_comb begin
        ld_nxt = resetn_in;
        off_nxt = (!resetn_in || shed_en_in) ? 5'h00 : off_r + {4'h0, off_r != 5'h1F};
    end
    always_ff @(posedge ref_clk_in) begin
        ld_r <= ld_nxt;
        off_r <= off_nxt;
    end
    assign req = cmd_valid_in && ld_r;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    a_answer_has_cause: assert property ((cmd_ack_out || cmd_nack_out) |->
        $past(cmd_valid_in) && !(cmd_ack_out && cmd_nack_out)) else $error("answer without request");
    a_request_answered: assert property (req |=> cmd_ack_out != cmd_nack_out)
        else $error("request not answered");
    a_cfg_word_only: assert property (req && cmd_code_in == `PST_CMD_CFG && !cmd_word_in |=> cmd_nack_out)
        else $error("non-word access accepted");
    a_page_range: assert property (req && cmd_write_in && cmd_code_in == `PST_CMD_PAGE
        |=> cmd_ack_out) else $error("page write refused");
    a_serial_no_write: assert property (req && cmd_write_in && cmd_code_in == `PST_CMD_SERIAL
        |=> cmd_nack_out) else $error("serial write accepted");
    a_rdata_holds: assert property (!cmd_ack_out && !cmd_nack_out |-> $stable(cmd_rdata_out))
        else $error("read data moved");
    a_phase_one_step: assert property ({1'b0, phases_a_out} <= {1'b0, $past(phases_a_out)} + 4'h1
        && {1'b0, $past(phases_a_out)} <= {1'b0, phases_a_out} + 4'h1) else $error("phase jump");
    a_phase_max: assert property (phases_a_out <= 3'h6 && phases_b_out <= 3'h3 && phases_a_out != 3'h0)
        else $error("phase count out of range");
    a_light_single: assert property (light_load_a_out |-> phases_a_out == 3'h1
        || $past(phases_a_out) == 3'h1) else $error("light load with several phases");
    a_shed_off_max: assert property (off_r >= 5'h10 |-> phases_a_out == 3'h6 && phases_b_out == 3'h3)
        else $error("shedding off but not at maximum");
    cover property (req && cmd_code_in == `PST_CMD_CFG && !cmd_write_in);
    cover property (phases_a_out == 3'h6);
    cover property (light_load_a_out);
endmodule
`default_nettype wire

// File: verif/pst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pst_host_model
    import pst_pkg::*;
(
    // clock
    input  wire logic      ref_clk_in,
    // answers
    input  wire logic      cmd_ack_in,
    input  wire logic      cmd_nack_in,
    input  wire pst_word_t cmd_rdata_in,
    // requests
    output logic           cmd_valid_out,
    output logic           cmd_write_out,
    output logic           cmd_word_out,
    output pst_cmd_t       cmd_code_out,
    output pst_word_t      cmd_wdata_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_word_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_wdata_out = 16'h0000;
    end
    // one paged word request, answer one cycle later
    task automatic xfer(input logic wr, input logic wd, input pst_cmd_t code, input pst_word_t data,
                        output logic ack, output logic nack, output pst_word_t rd);
        @(posedge ref_clk_in);
        cmd_valid_out <= 1'b1;
        cmd_write_out <= wr;
        cmd_word_out <= wd;
        cmd_code_out <= code;
        cmd_wdata_out <= data;
        @(posedge ref_clk_in);
        cmd_valid_out <= 1'b0;
        // released data is not left showing the last word
        cmd_wdata_out <= ~data;
        #1;
        ack = cmd_ack_in;
        nack = cmd_nack_in;
        rd = cmd_rdata_in;
    endtask
endmodule
`default_nettype wire

// File: verif/pst_cfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pst_cfg_map.svh"
module pst_cfg_top_tb
    import pst_pkg::*;
;
    typedef struct packed {
        logic      wr;
        logic      wd;
        pst_cmd_t  code;
        pst_word_t data;
        logic      ack;
        logic      rchk;
        pst_word_t rexp;
    } pst_row_s;
    localparam pst_word_t NVM_A = 16'h2A47;
    localparam pst_word_t NVM_B = 16'h1C96;
    localparam pst_word_t SUM = NVM_A + {NVM_B[7:0], NVM_B[15:8]} + 16'h5A5A;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       shed_en = 1'b1;
    pst_amp_t   avg_a = 10'h000;
    pst_amp_t   peak_a = 10'h000;
    pst_amp_t   peak_b = 10'h000;
    logic       valid, wr, wd, ack, nack, ll_a, ll_b, ack_s, nack_s;
    pst_cmd_t   code;
    pst_word_t  wdata, rdata, rd_s;
    pst_phase_t ph_a, ph_b;
    pst_row_s   rows [16];
    int         failures = 0;
    int         n_checks = 0;
    always #5 clk = ~clk;
    pst_cfg_top uut (.ref_clk_in(clk), .resetn_in(resetn), .nvm_cfg_a_in(NVM_A), .nvm_cfg_b_in(NVM_B),
        .cmd_valid_in(valid), .cmd_write_in(wr), .cmd_word_in(wd), .cmd_code_in(code), .cmd_wdata_in(wdata),
        .cmd_ack_out(ack), .cmd_nack_out(nack), .cmd_rdata_out(rdata), .shed_en_in(shed_en),
        .avg_cur_a_in(avg_a), .peak_cur_a_in(peak_a), .avg_cur_b_in(10'h000), .peak_cur_b_in(peak_b),
        .phases_a_out(ph_a), .phases_b_out(ph_b), .light_load_a_out(ll_a), .light_load_b_out(ll_b));
    pst_host_model host (.ref_clk_in(clk), .cmd_ack_in(ack), .cmd_nack_in(nack), .cmd_rdata_in(rdata),
        .cmd_valid_out(valid), .cmd_write_out(wr), .cmd_word_out(wd), .cmd_code_out(code), .cmd_wdata_out(wdata));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // currents go to zero first so no phase is added before the new word lands
    task do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        avg_a <= 10'h000;
        peak_a <= 10'h000;
        peak_b <= 10'h000;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
    endtask
    task cmd(input logic w, input logic d, input pst_cmd_t c, input pst_word_t v, input logic exp_ack);
        host.xfer(w, d, c, v, ack_s, nack_s, rd_s);
        check(16'(ack_s), 16'(exp_ack));
        check(16'(nack_s), 16'(!exp_ack));
    endtask
    // phase moves need sync plus one step a cycle, 16 cycles is ample
    task step(input pst_amp_t avg, input pst_amp_t pk, input pst_phase_t ph, input logic ll);
        @(posedge clk);
        avg_a <= avg;
        peak_a <= pk;
        repeat (16) @(posedge clk);
        #1;
        check(16'(ph_a), 16'(ph));
        check(16'(ll_a), 16'(ll));
    endtask
    initial begin
        #20000;
        failures++;
        summarize;
    end
    initial begin
        rows = '{'{1'h1, 1'h0, `PST_CMD_PAGE, 16'h0000, 1'h1, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h1, 1'h1, NVM_A},
                 '{1'h0, 1'h1, `PST_CMD_SERIAL, 16'h0000, 1'h1, 1'h1, SUM},
                 '{1'h1, 1'h0, `PST_CMD_PAGE, 16'h0001, 1'h1, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h1, 1'h1, NVM_B},
                 '{1'h1, 1'h1, `PST_CMD_CFG, 16'hFFFF, 1'h1, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h1, 1'h1, 16'hFFFF},
                 '{1'h0, 1'h0, `PST_CMD_CFG, 16'h0000, 1'h0, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, 8'hB1, 16'h0000, 1'h1, 1'h1, 16'hFFFF},
                 '{1'h0, 1'h1, 8'hC0, 16'h0000, 1'h0, 1'h0, 16'h0000},
                 '{1'h1, 1'h0, `PST_CMD_PAGE, 16'h0002, 1'h1, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h0, 1'h0, 16'h0000},
                 '{1'h1, 1'h1, `PST_CMD_SERIAL, 16'h1234, 1'h0, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, 8'h55, 16'h0000, 1'h0, 1'h0, 16'h0000},
                 '{1'h1, 1'h0, `PST_CMD_PAGE, 16'h0000, 1'h1, 1'h0, 16'h0000},
                 '{1'h0, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h1, 1'h1, NVM_A}};
        do_reset;
        foreach (rows[i]) begin
            cmd(rows[i].wr, rows[i].wd, rows[i].code, rows[i].data, rows[i].ack);
            if (rows[i].rchk)
                check(rd_s, rows[i].rexp);
        end
        cmd(1'h1, 1'h1, `PST_CMD_CFG, 16'hE008, 1'h1);
        for (int k = 1; k <= 5; k++) begin
            step(10'h014, 10'(k * 12 + 5), 3'(k), k == 1);
            step(10'h014, 10'(k * 12 + 6), 3'(k + 1), 1'h0);
        end
        step(10'h014, 10'h3FF, 3'h6, 1'h0);
        do_reset;
        cmd(1'h1, 1'h0, `PST_CMD_PAGE, 16'h0000, 1'h1);
        cmd(1'h1, 1'h1, `PST_CMD_CFG, 16'hE008, 1'h1);
        step(10'h014, 10'h012, 3'h2, 1'h0);
        step(10'h011, 10'h000, 3'h2, 1'h0);
        step(10'h010, 10'h000, 3'h1, 1'h1);
        do_reset;
        cmd(1'h1, 1'h0, `PST_CMD_PAGE, 16'h0000, 1'h1);
        cmd(1'h1, 1'h1, `PST_CMD_CFG, 16'h6033, 1'h1);
        step(10'h014, 10'h01D, 3'h1, 1'h0);
        step(10'h014, 10'h01E, 3'h2, 1'h0);
        step(10'h000, 10'h000, 3'h2, 1'h0);
        cmd(1'h1, 1'h0, `PST_CMD_PAGE, 16'h0001, 1'h1);
        cmd(1'h1, 1'h1, `PST_CMD_CFG, 16'h0000, 1'h1);
        @(posedge clk);
        peak_b <= 10'h3FF;
        step(10'h000, 10'h000, 3'h2, 1'h0);
        check(16'(ph_b), 16'h0003);
        check(16'(ll_b), 16'h0000);
        @(posedge clk);
        shed_en <= 1'b0;
        step(10'h000, 10'h000, 3'h6, 1'h0);
        step(10'h000, 10'h000, 3'h6, 1'h0);
        summarize;
    end
endmodule
bind pst_cfg_top pst_cfg_top_checker chk (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_word_in(cmd_word_in),
    .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .cmd_ack_out(cmd_ack_out),
    .cmd_nack_out(cmd_nack_out), .cmd_rdata_out(cmd_rdata_out), .shed_en_in(shed_en_in),
    .phases_a_out(phases_a_out), .phases_b_out(phases_b_out), .light_load_a_out(light_load_a_out));
`default_nettype wire
